/* include/cbs_pkg.sv */
// constants and types for the ccd binning and paired-image sequencer
package cbs_pkg;

	// ==========================================
	// timing
	localparam int CLK_HZ     = 100_000_000;
	localparam int CLK_NS     = 10;
	localparam int FAST_HZ    = 1_000_000;
	localparam int SLOW_HZ    = 100_000;
	localparam int EXP_UNIT_NS = 1000;
	localparam int CLEAN_NS   = 400;
	localparam int PRE_W      = 10;
	localparam logic [PRE_W-1:0] FAST_DIV  = PRE_W'(CLK_HZ / FAST_HZ);
	localparam logic [PRE_W-1:0] SLOW_DIV  = PRE_W'(CLK_HZ / SLOW_HZ);
	localparam logic [PRE_W-1:0] US_DIV    = PRE_W'((EXP_UNIT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [PRE_W-1:0] CLEAN_DIV = PRE_W'((CLEAN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [PRE_W-1:0] PRE_ONE   = 10'h001;

	// ==========================================
	// register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] A_EXP1 = 8'h04;
	localparam logic [ADDR_W-1:0] A_EXP2 = 8'h08;
	localparam logic [ADDR_W-1:0] A_BIN  = 8'h0C;
	localparam logic [ADDR_W-1:0] A_SIZE = 8'h10;
	localparam logic [ADDR_W-1:0] A_STAT = 8'h14;

	// ==========================================
	// fields and widths
	localparam int CTRL_START   = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int MODE_W       = 2;
	localparam int CTRL_SLOW    = 3;
	localparam int CTRL_BITS_LO = 4;
	localparam int BITS_W       = 4;
	localparam int BIN_W        = 8;
	localparam int BIN_ROW_LO   = 0;
	localparam int BIN_COL_LO   = 8;
	localparam int DIM_W        = 12;
	localparam int SIZE_ROW_LO  = 0;
	localparam int SIZE_COL_LO  = 16;
	localparam int ST_W         = 12;
	localparam int STAT_FRAME   = 12;
	localparam int STAT_READY_N = 13;
	localparam int STAT_SHUT    = 14;
	localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_00C0;
	localparam logic [DATA_W-1:0] EXP_RST  = 32'h0000_0001;
	localparam logic [DATA_W-1:0] BIN_RST  = 32'h0000_0101;
	localparam logic [DATA_W-1:0] SIZE_RST = 32'h0008_0008;
	localparam logic [DATA_W-1:0] EXP_ONE  = 32'h0000_0001;
	localparam logic [BIN_W-1:0]  BIN_ONE  = 8'h01;
	localparam logic [DIM_W-1:0]  DIM_ONE  = 12'h001;

	typedef enum logic [MODE_W-1:0] {
		MODE_SINGLE = 2'h0,
		MODE_EQUAL  = 2'h1,
		MODE_EXT    = 2'h2,
		MODE_SHUT   = 2'h3
	} cbs_mode_e;

	typedef enum logic [ST_W-1:0] {
		ST_IDLE   = 12'h001,
		ST_OPEN   = 12'h002,
		ST_ARMED  = 12'h004,
		ST_EXP1   = 12'h008,
		ST_GAP    = 12'h010,
		ST_EXP2   = 12'h020,
		ST_CLOSE  = 12'h040,
		ST_HEADER = 12'h080,
		ST_XFER   = 12'h100,
		ST_VSHIFT = 12'h200,
		ST_HSHIFT = 12'h400,
		ST_CONV   = 12'h800
	} cbs_state_e;

endpackage

/* hw/cbs_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module cbs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d_i;
			q_reg    <= meta_reg;
		end
	end

	assign q_o = q_reg;
endmodule

/* hw/cbs_seq.sv */
// readout and paired-image acquisition sequencer with register port
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module cbs_seq import cbs_pkg::*; (
	input  wire logic              mclk_i,
	input  wire logic              reset_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	input  wire logic              ext_sync_i,
	input  wire logic              shutter_open_i,
	input  wire logic              shutter_closed_i,
	input  wire logic [BITS_W-1:0] hw_bits_i,
	output logic                   shutter_o,
	output logic                   ready_n_o,
	output logic                   clean_o,
	output logic                   exposing_o,
	output logic                   xfer_o,
	output logic                   vshift_o,
	output logic                   hshift_o,
	output logic                   sample_o,
	output logic                   header_o,
	output logic                   frame_o,
	output logic                   rate_slow_o,
	output logic      [BITS_W-1:0] pix_bits_o
);
	// ==========================================
	// pin synchronisers
	logic [2:0]        pins_s;
	logic [BITS_W-1:0] hw_bits_s;
	logic              sync_d_reg;

	cbs_sync #(.WIDTH(3)) u_pins (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.d_i     ({shutter_closed_i, shutter_open_i, ext_sync_i}),
		.q_o     (pins_s)
	);

	cbs_sync #(.WIDTH(BITS_W)) u_bits (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.d_i     (hw_bits_i),
		.q_o     (hw_bits_s)
	);

	wire sync_rise = pins_s[0] & ~sync_d_reg;
	wire open_s    = pins_s[1];
	wire closed_s  = pins_s[2];

	// ==========================================
	// register file
	logic [DATA_W-1:0] ctrl_reg;
	logic [DATA_W-1:0] exp1_reg;
	logic [DATA_W-1:0] exp2_reg;
	logic [DATA_W-1:0] bin_reg;
	logic [DATA_W-1:0] size_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [DATA_W-1:0] stat_w;

	wire wr_ctrl = wr_i && (addr_i == A_CTRL);
	wire wr_exp1 = wr_i && (addr_i == A_EXP1);
	wire wr_exp2 = wr_i && (addr_i == A_EXP2);
	wire wr_bin  = wr_i && (addr_i == A_BIN);
	wire wr_size = wr_i && (addr_i == A_SIZE);
	wire start   = wr_ctrl && wdata_i[CTRL_START];

	// mode steers the whole acquisition sequence
	wire cbs_mode_e        mode = cbs_mode_e'(ctrl_reg[CTRL_MODE_LO +: MODE_W]);
	wire                   slow = ctrl_reg[CTRL_SLOW];
	wire [BITS_W-1:0]      cfg_bits = ctrl_reg[CTRL_BITS_LO +: BITS_W];
	wire [BIN_W-1:0]       rbin_raw = bin_reg[BIN_ROW_LO +: BIN_W];
	wire [BIN_W-1:0]       cbin_raw = bin_reg[BIN_COL_LO +: BIN_W];
	// zero factor counts as one; factors are independent
	wire [BIN_W-1:0]       rbin = (rbin_raw == '0) ? BIN_ONE : rbin_raw;
	wire [BIN_W-1:0]       cbin = (cbin_raw == '0) ? BIN_ONE : cbin_raw;
	wire [DIM_W-1:0]       rows = size_reg[SIZE_ROW_LO +: DIM_W];
	wire [DIM_W-1:0]       cols = size_reg[SIZE_COL_LO +: DIM_W];
	// exposure counts in microseconds, one at least
	wire [DATA_W-1:0]      len1 = (exp1_reg == '0) ? EXP_ONE : exp1_reg;
	wire [DATA_W-1:0]      len2x = (exp2_reg == '0) ? EXP_ONE : exp2_reg;
	wire [DATA_W-1:0]      len2 = (mode == MODE_EXT) ? len2x : len1;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ctrl_reg <= CTRL_RST;
			exp1_reg <= EXP_RST;
			exp2_reg <= EXP_RST;
			bin_reg  <= BIN_RST;
			size_reg <= SIZE_RST;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= {wdata_i[DATA_W-1:1], 1'b0};
			if (wr_exp1)
				exp1_reg <= wdata_i;
			if (wr_exp2)
				exp2_reg <= wdata_i;
			if (wr_bin)
				bin_reg <= wdata_i;
			if (wr_size)
				size_reg <= wdata_i;
		end
	end

	// ==========================================
	// sequencer state
	cbs_state_e       state_reg;
	cbs_state_e       state_next;
	logic [DATA_W-1:0] cnt_reg;
	logic [DATA_W-1:0] cnt_next;
	logic [DIM_W-1:0]  row_reg;
	logic [DIM_W-1:0]  row_next;
	logic [DIM_W-1:0]  col_reg;
	logic [DIM_W-1:0]  col_next;
	logic [PRE_W-1:0]  pre_reg;
	logic [PRE_W-1:0]  div_sel;
	logic              second_reg;
	logic              second_next;
	logic              xfer_next;
	logic              vshift_next;
	logic              hshift_next;
	logic              sample_next;
	logic              header_next;

	wire readout = (state_reg == ST_VSHIFT) || (state_reg == ST_HSHIFT) ||
		(state_reg == ST_CONV);
	wire exp_st  = (state_reg == ST_EXP1) || (state_reg == ST_EXP2);
	// readout steps run at the selected conversion rate
	assign div_sel = readout ? (slow ? SLOW_DIV : FAST_DIV) :
		((state_reg == ST_OPEN) ? CLEAN_DIV : US_DIV);
	wire tick    = (pre_reg == div_sel - PRE_ONE);
	wire moving  = (state_next != state_reg);
	wire last_v  = (cnt_reg == DATA_W'(rbin) - EXP_ONE);
	wire last_h  = (cnt_reg == DATA_W'(cbin) - EXP_ONE);
	wire paired  = (mode != MODE_SINGLE);

	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		row_next    = row_reg;
		col_next    = col_reg;
		second_next = second_reg;
		xfer_next   = 1'b0;
		vshift_next = 1'b0;
		hshift_next = 1'b0;
		sample_next = 1'b0;
		header_next = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next  = ST_OPEN;
					second_next = 1'b0;
				end
			end
			ST_OPEN: begin
				// cleaning pass done and shutter fully open
				if (tick && open_s)
					state_next = ST_ARMED;
			end
			ST_ARMED: begin
				// only the armed state and, in shutter mode, the gap state answer the sync input
				if (sync_rise) begin
					state_next = ST_EXP1;
					cnt_next   = len1;
				end
			end
			ST_EXP1: begin
				if (tick) begin
					cnt_next = cnt_reg - EXP_ONE;
					if (cnt_reg == EXP_ONE) begin
						xfer_next = 1'b1;
						if (!paired)
							state_next = ST_CLOSE;
						else if (mode == MODE_SHUT)
							state_next = ST_GAP;
						else begin
							state_next = ST_EXP2;
							cnt_next   = len2;
						end
					end
				end
			end
			ST_GAP: begin
				if (sync_rise) begin
					state_next = ST_EXP2;
					cnt_next   = len1;
				end
			end
			ST_EXP2: begin
				if (tick) begin
					cnt_next = cnt_reg - EXP_ONE;
					// no transfer: image two waits in the photodiodes
					if (cnt_reg == EXP_ONE)
						state_next = ST_CLOSE;
				end
			end
			ST_CLOSE: begin
				if (closed_s)
					state_next = ST_HEADER;
			end
			ST_HEADER, ST_XFER: begin
				header_next = (state_reg == ST_HEADER);
				xfer_next   = (state_reg == ST_XFER);
				state_next  = ST_VSHIFT;
				cnt_next    = '0;
				row_next    = '0;
			end
			ST_VSHIFT: begin
				if (tick) begin
					vshift_next = 1'b1;
					row_next    = row_reg + DIM_ONE;
					cnt_next    = cnt_reg + EXP_ONE;
					// rows pile up in the readout register, no horizontal step
					if (last_v) begin
						state_next = ST_HSHIFT;
						cnt_next   = '0;
						col_next   = '0;
					end
				end
			end
			ST_HSHIFT: begin
				if (tick) begin
					hshift_next = 1'b1;
					col_next    = col_reg + DIM_ONE;
					cnt_next    = cnt_reg + EXP_ONE;
					if (last_h)
						state_next = ST_CONV;
				end
			end
			ST_CONV: begin
				if (tick) begin
					sample_next = 1'b1;
					cnt_next    = '0;
					if (col_reg < cols)
						state_next = ST_HSHIFT;
					else if (row_reg < rows)
						state_next = ST_VSHIFT;
					else if (paired && !second_reg) begin
						state_next  = ST_XFER;
						second_next = 1'b1;
					end else
						state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_reg  <= ST_IDLE;
			cnt_reg    <= '0;
			row_reg    <= '0;
			col_reg    <= '0;
			pre_reg    <= '0;
			second_reg <= 1'b0;
			sync_d_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			row_reg    <= row_next;
			col_reg    <= col_next;
			pre_reg    <= (moving || tick) ? '0 : pre_reg + PRE_ONE;
			second_reg <= second_next;
			sync_d_reg <= pins_s[0];
		end
	end

	// ==========================================
	// registered outputs
	wire shut_next = (state_next == ST_OPEN) || (state_next == ST_ARMED) ||
		(state_next == ST_EXP1) || (state_next == ST_GAP) || (state_next == ST_EXP2);
	wire [BITS_W-1:0] bits_next = (cfg_bits < hw_bits_s) ? cfg_bits : hw_bits_s;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			shutter_o   <= 1'b0;
			ready_n_o   <= 1'b1;
			clean_o     <= 1'b0;
			exposing_o  <= 1'b0;
			xfer_o      <= 1'b0;
			vshift_o    <= 1'b0;
			hshift_o    <= 1'b0;
			sample_o    <= 1'b0;
			header_o    <= 1'b0;
			frame_o     <= 1'b0;
			rate_slow_o <= 1'b0;
			pix_bits_o  <= '0;
		end else begin
			shutter_o   <= shut_next;
			ready_n_o   <= (state_next != ST_ARMED);
			clean_o     <= (state_next == ST_OPEN) || (state_next == ST_ARMED);
			exposing_o  <= (state_next == ST_EXP1) || (state_next == ST_EXP2);
			xfer_o      <= xfer_next;
			vshift_o    <= vshift_next;
			hshift_o    <= hshift_next;
			sample_o    <= sample_next;
			header_o    <= header_next;
			frame_o     <= second_reg;
			rate_slow_o <= slow;
			pix_bits_o  <= bits_next;
		end
	end

	// ==========================================
	// read port
	assign stat_w = {17'h0_0000, shutter_o, ready_n_o, second_reg, state_reg};

	always_comb begin
		unique case (addr_i)
			A_CTRL:  rdata_next = ctrl_reg;
			A_EXP1:  rdata_next = exp1_reg;
			A_EXP2:  rdata_next = exp2_reg;
			A_BIN:   rdata_next = bin_reg;
			A_SIZE:  rdata_next = size_reg;
			A_STAT:  rdata_next = stat_w;
			default: rdata_next = '0;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i)
			rdata_reg <= '0;
		else
			rdata_reg <= rd_i ? rdata_next : '0;
	end

	assign rdata_o = rdata_reg;

	// ==========================================
	// checks
	logic [DATA_W+PRE_W-1:0] st_cyc_reg;
	logic [BIN_W-1:0]        h_cnt_reg;
	wire [DATA_W+PRE_W-1:0]  want1 = (DATA_W+PRE_W)'(len1) * (DATA_W+PRE_W)'(US_DIV);
	wire [DATA_W+PRE_W-1:0]  want2 = (DATA_W+PRE_W)'(len2) * (DATA_W+PRE_W)'(US_DIV);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st_cyc_reg <= '0;
			h_cnt_reg  <= '0;
		end else begin
			st_cyc_reg <= moving ? '0 : st_cyc_reg + 1'b1;
			h_cnt_reg  <= sample_o ? '0 : h_cnt_reg + BIN_W'(hshift_o);
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	a_ready_armed: assert property (!ready_n_o |-> state_reg == ST_ARMED)
		else $error("ready low outside the armed state");
	a_sync_gated: assert property ($rose(state_reg == ST_EXP1) |->
		$past(state_reg == ST_ARMED) && $past(sync_rise))
		else $error("exposure began without an armed sync edge");
	a_first_xfer: assert property ($fell(state_reg == ST_EXP1) |-> xfer_o)
		else $error("first image not moved to storage at exposure end");
	a_hold_second: assert property ($fell(state_reg == ST_EXP2) |->
		!xfer_o && state_reg == ST_CLOSE)
		else $error("second image moved before shutter close");
	a_close_first: assert property ($rose(state_reg == ST_HEADER) |-> $past(closed_s))
		else $error("readout started with shutter not closed");
	a_exp1_len: assert property (state_reg == ST_EXP1 && moving |->
		st_cyc_reg == want1 - 1'b1)
		else $error("first exposure length wrong");
	a_exp2_len: assert property (state_reg == ST_EXP2 && moving |->
		st_cyc_reg == want2 - 1'b1)
		else $error("second exposure length wrong");
	a_col_group: assert property (sample_o |-> h_cnt_reg == cbin)
		else $error("sample strobe without a full column group");
	a_row_group: assert property ($fell(state_reg == ST_VSHIFT) |->
		vshift_o && !hshift_o ##1 !hshift_o [*8])
		else $error("horizontal shift before row group complete");
	a_header_lead: assert property (header_o |-> !sample_o [*3])
		else $error("sample right after header");
	a_bits_min: assert property (pix_bits_o <= $past(hw_bits_s))
		else $error("pixel width exceeds fitted width");

	c_single: cover property ($fell(state_reg == ST_EXP1) && mode == MODE_SINGLE);
	c_paired: cover property ($rose(state_reg == ST_XFER));
	c_gap:    cover property ($rose(state_reg == ST_GAP) ##[1:1000] state_reg == ST_EXP2);
endmodule

/* test/cbs_far_side.sv */
// shutter and trigger source model facing the sequencer
`timescale 1ns/10ps
module cbs_far_side #(
	parameter int OPEN_DLY  = 20,
	parameter int CLOSE_DLY = 30,
	parameter int SYNC_PER  = 250
) (
	input  wire logic mclk_i,
	input  wire logic reset_i,
	input  wire logic trig_en_i,
	input  wire logic shutter_i,
	output logic      ext_sync_o,
	output logic      open_o,
	output logic      closed_o
);
	logic cmd_reg;
	int   move_cnt;
	int   sync_cnt;

	// ==========================================
	// shutter blades travel for a while and touch neither end stop meanwhile
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cmd_reg <= 1'b0;
			move_cnt <= 0;
			open_o <= 1'b0;
			closed_o <= 1'b1;
		end else if (shutter_i != cmd_reg) begin
			cmd_reg <= shutter_i;
			move_cnt <= shutter_i ? OPEN_DLY : CLOSE_DLY;
			open_o <= 1'b0;
			closed_o <= 1'b0;
		end else if (move_cnt > 1) begin
			move_cnt <= move_cnt - 1;
		end else if (move_cnt == 1) begin
			move_cnt <= 0;
			open_o <= cmd_reg;
			closed_o <= !cmd_reg;
		end
	end

	// ==========================================
	// trigger runs free, so pulses also land while the camera is not armed
	always_ff @(posedge mclk_i) begin
		if (reset_i || !trig_en_i) begin
			sync_cnt <= 0;
			ext_sync_o <= 1'b0;
		end else begin
			sync_cnt <= (sync_cnt == SYNC_PER - 1) ? 0 : sync_cnt + 1;
			ext_sync_o <= (sync_cnt < 2);
		end
	end
endmodule

/* test/testbench.sv */
// self-checking bench for the readout and paired-image sequencer
`timescale 1ns/10ps
module testbench import cbs_pkg::*;;
	logic              mclk_i    = 1'b0;
	logic              reset_i   = 1'b1;
	logic [ADDR_W-1:0] addr_i    = 8'h00;
	logic [DATA_W-1:0] wdata_i   = 32'h0000_0000;
	logic              wr_i      = 1'b0;
	logic              rd_i      = 1'b0;
	logic              trig_en   = 1'b0;
	logic [BITS_W-1:0] hw_bits_i = 4'hC;
	logic [DATA_W-1:0] rdata_o;
	logic              ext_sync_i, shutter_open_i, shutter_closed_i, shutter_o, ready_n_o;
	logic              clean_o, exposing_o, xfer_o, vshift_o, hshift_o, sample_o;
	logic              header_o, frame_o, rate_slow_o, sync_q, prev_ready_n;
	logic [BITS_W-1:0] pix_bits_o;
	logic [31:0]       seed = 32'hbcf7_acfc;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	int n_v, n_h, n_s, n_s2, n_x, n_hd, n_exp, min_gap, last_step, sync_at, lat, bad, early;

	cbs_seq uut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_sync_i(ext_sync_i),
		.shutter_open_i(shutter_open_i), .shutter_closed_i(shutter_closed_i),
		.hw_bits_i(hw_bits_i), .shutter_o(shutter_o), .ready_n_o(ready_n_o), .clean_o(clean_o),
		.exposing_o(exposing_o), .xfer_o(xfer_o), .vshift_o(vshift_o), .hshift_o(hshift_o),
		.sample_o(sample_o), .header_o(header_o), .frame_o(frame_o),
		.rate_slow_o(rate_slow_o), .pix_bits_o(pix_bits_o));

	cbs_far_side far_side (.mclk_i(mclk_i), .reset_i(reset_i), .trig_en_i(trig_en),
		.shutter_i(shutter_o), .ext_sync_o(ext_sync_i), .open_o(shutter_open_i),
		.closed_o(shutter_closed_i));

	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) cyc <= cyc + 1;

	// ==========================================
	// model side: count what the array and converter are told to do
	always @(negedge mclk_i) begin
		if (ext_sync_i === 1'b1 && sync_q !== 1'b1) sync_at = cyc;
		sync_q = ext_sync_i;
		if (prev_ready_n === 1'b0 && ready_n_o === 1'b1) lat = cyc - sync_at;
		if (exposing_o === 1'b1) begin
			n_exp++;
			if (n_exp == 1 && prev_ready_n !== 1'b0) early++;
		end
		if (xfer_o === 1'b1 && n_x >= 1 && n_hd == 0) bad++;
		if (exposing_o === 1'b1 && (shutter_o !== 1'b1 || clean_o !== 1'b0)) bad++;
		if (ready_n_o === 1'b0 && clean_o !== 1'b1) bad++;
		if (vshift_o === 1'b1 && (n_x == 0 || shutter_closed_i !== 1'b1)) bad++;
		n_x += (xfer_o === 1'b1);
		n_hd += (header_o === 1'b1);
		n_v += (vshift_o === 1'b1);
		n_h += (hshift_o === 1'b1);
		n_s += (sample_o === 1'b1);
		n_s2 += (sample_o === 1'b1 && frame_o === 1'b1);
		if ((vshift_o | hshift_o | sample_o) === 1'b1) begin
			if (cyc - last_step < min_gap) min_gap = cyc - last_step;
			last_step = cyc;
		end
		prev_ready_n = ready_n_o;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic conclude();
		if (failures == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic check_n(input string what, input int exp, input int got);
		num_checks++;
		if (exp != got) begin
			failures++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic check_v(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (exp !== got) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ==========================================
	// register port
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(negedge mclk_i);
		check_v(what, e, rdata_o & m);
	endtask

	// ==========================================
	// one acquisition against the counting model
	task automatic acq(input int mode, rows, cols, rb, cb, e1, e2, slow);
		int rg, cg, fr, per, k;
		logic [3:0] bits, hw;
		rg = (rows + rb - 1) / rb;
		cg = (cols + cb - 1) / cb;
		fr = (mode == 0) ? 1 : 2;
		per = slow ? 1000 : 100;
		hw = 4'(rnd());
		bits = 4'(rnd());
		hw_bits_i <= hw;
		wr(A_EXP1, e1);
		wr(A_EXP2, e2);
		wr(A_BIN, (cb << 8) | rb);
		wr(A_SIZE, (cols << 16) | rows);
		rd_chk("bin", A_BIN, (cb << 8) | rb, 32'hFFFF_FFFF);
		{n_v, n_h, n_s, n_s2, n_x, n_hd, n_exp, bad, early, lat} = '0;
		min_gap = 1 << 30;
		last_step = -100000;
		wr(A_CTRL, {24'h00_0000, bits, 1'(slow), 2'(mode), 1'b1});
		for (k = 0; k < 60000 && n_s < rg * cg * fr; k++) @(posedge mclk_i);
		repeat (per + 50) @(posedge mclk_i);
		check_n("vshift", rg * rb * fr, n_v);
		check_n("hshift", rg * cg * cb * fr, n_h);
		check_n("samples", rg * cg * fr, n_s);
		check_n("frame two samples", rg * cg * (fr - 1), n_s2);
		check_n("headers", 1, n_hd);
		check_n("transfers", fr, n_x);
		check_n("order faults", 0, bad);
		check_n("step spacing", per, min_gap);
		check_n("exposure us", (mode == 2) ? e1 + e2 : e1 * fr, (n_exp + 50) / 100);
		check_n("sync to ready", 3, lat);
		check_n("early start", 0, early);
		check_v("rate", 32'(slow), 32'(rate_slow_o));
		check_v("pixel bits", 32'((bits < hw) ? bits : hw), 32'(pix_bits_o));
		rd_chk("status", A_STAT, 32'h0000_2001, 32'h0000_6FFF);
	endtask

	logic [31:0] rst_tab [7] = '{CTRL_RST, EXP_RST, EXP_RST, BIN_RST, SIZE_RST,
		32'h0000_2001, 32'h0000_0000};

	initial begin
		repeat (4) @(posedge mclk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 7; i++) rd_chk("reset value", 8'(i * 4), rst_tab[i], '1);
		wr(8'h18, 32'h0000_00FF);
		wr(A_STAT, 32'h0000_FFFF);
		rd_chk("unmapped", 8'h18, 32'h0000_0000, '1);
		rd_chk("read only", A_STAT, 32'h0000_2001, '1);
		trig_en <= 1'b1;
		acq(0, 1, 1, 1, 1, 1, 1, 0);
		acq(1, 2, 2, 2, 2, 1, 3, 0);
		for (int m = 0; m < 4; m++) begin
			acq(m, 1 + rnd() % 3, 1 + rnd() % 3, 1 + rnd() % 2, 1 + rnd() % 2, 1 + rnd() % 2,
				1 + rnd() % 3, 0);
		end
		acq(3, 1, 1, 1, 1, 2, 1, 1);
		conclude();
	end

	// between three and five times the cycles that all acquisitions above should take
	initial begin
		#800_000;
		failures++;
		conclude();
	end
endmodule
